// ### hw/irq_regs.svh
// register offsets, field positions and reset values of the interrupt logic
`ifndef IRQ_REGS_SVH
`define IRQ_REGS_SVH

`define OFS_MASTER_CONTROL 8'h23
`define OFS_MASTER_STATUS 8'h24
`define OFS_CAMERA_TX_STATUS 8'h37
`define OFS_PORT_SELECT 8'h4C
`define OFS_PORT_STATUS_FIRST 8'h4D
`define OFS_PORT_STATUS_SECOND 8'h4E
`define OFS_CAMERA_RX_STATUS 8'h7A
`define OFS_PORT_ENABLE_HIGH 8'hD8
`define OFS_PORT_ENABLE_LOW 8'hD9
`define OFS_PORT_MIRROR_HIGH 8'hDA
`define OFS_PORT_MIRROR_LOW 8'hDB
`define OFS_GPIO_CONTROL_BASE 8'h10

`define GPIO_COUNT 4
`define OPENDRAIN_GPIO_INDEX 3

`define BIT_MASTER_ENABLE 7
`define BIT_CAMERA_TX_ENABLE 4
`define BIT_PORT1_ENABLE 1
`define BIT_PORT0_ENABLE 0
`define BIT_STATUS_GLOBAL 7
`define BIT_STATUS_CAMERA_TX 4
`define BIT_STATUS_PORT1 1
`define BIT_STATUS_PORT0 0

`define BIT_GPIO_OUT_ENABLE 0
`define BIT_GPIO_OUT_VALUE 1
`define BIT_GPIO_IRQ_SELECT 2

`define RESET_MASTER_CONTROL 8'h00
`define RESET_PORT_ENABLE 8'h00
`define RESET_PORT_SELECT 8'h01
`define RESET_GPIO_CONTROL 8'h00

`endif

// ### hw/irq_pkg.sv
// types shared by the interrupt logic
package irq_pkg;

   // one-cycle condition pulses raised by one receive port
   typedef struct packed {
      logic bcc_crc_err;
      logic lock_chg;
      logic bcc_seq_err;
      logic parity_err;
      logic pass_chg;
      logic line_len_chg;
      logic enc_err;
      logic buffer_err;
      logic line_cnt_chg;
      logic [3:0] camera_rx_err;
   } port_event_s;

   // register access port as seen from the serial control target
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_s;

   // per-port clear strobes produced by read decode
   typedef struct packed {
      logic status_first;
      logic status_second;
      logic camera_rx;
   } port_clear_s;

endpackage

// ### hw/port_irq_unit.sv
// sticky interrupt status, mirrors and enables of one receive port
`timescale 1ns/1ps
`include "irq_regs.svh"

module port_irq_unit (
   input wire logic mclk,
   input wire logic reset_n,
   input irq_pkg::port_event_s events,
   input wire logic pass_level,
   input wire logic lock_level,
   input wire logic wr_enable_high,
   input wire logic wr_enable_low,
   input wire logic [7:0] wdata,
   input irq_pkg::port_clear_s clear,
   output logic [7:0] status_first,
   output logic [7:0] status_second,
   output logic [7:0] camera_rx_status,
   output logic [7:0] mirror_high,
   output logic [7:0] mirror_low,
   output logic [7:0] enable_high,
   output logic [7:0] enable_low,
   output logic port_irq
);
   logic [7:0] enable_high_reg, enable_high_next;
   logic [7:0] enable_low_reg, enable_low_next;
   logic [4:0] first_reg, first_next;
   logic [3:0] second_reg, second_next;
   logic [3:0] camera_reg, camera_next;
   logic [4:0] first_set;
   logic [3:0] second_set;

   // -----------------------------------------------------------------
   // sticky conditions
   // -----------------------------------------------------------------
   always_comb begin
      first_set = {events.bcc_crc_err, events.lock_chg, events.bcc_seq_err,
                   events.parity_err, events.pass_chg};
      second_set = {events.line_len_chg, events.enc_err, events.buffer_err,
                    events.line_cnt_chg};
      // latching ignores the enables; a set in the clearing cycle survives
      first_next = (clear.status_first ? 5'h00 : first_reg) | first_set;
      second_next = (clear.status_second ? 4'h0 : second_reg) | second_set;
      camera_next = (clear.camera_rx ? 4'h0 : camera_reg) | events.camera_rx_err;
      enable_high_next = wr_enable_high ? wdata : enable_high_reg;
      enable_low_next = wr_enable_low ? wdata : enable_low_reg;
   end

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         first_reg <= 5'h00;
         second_reg <= 4'h0;
         camera_reg <= 4'h0;
         enable_high_reg <= `RESET_PORT_ENABLE;
         enable_low_reg <= `RESET_PORT_ENABLE;
      end else begin
         first_reg <= first_next;
         second_reg <= second_next;
         camera_reg <= camera_next;
         enable_high_reg <= enable_high_next;
         enable_low_reg <= enable_low_next;
      end
   end

   // -----------------------------------------------------------------
   // read views; the mirrors are copies and clear nothing
   // -----------------------------------------------------------------
   always_comb begin
      status_first = {2'b00, first_reg[4], first_reg[3], first_reg[2], first_reg[1],
                      pass_level, lock_level};
      status_second = {1'b0, second_reg[3], second_reg[2], second_reg[1], 3'b000,
                       second_reg[0]};
      camera_rx_status = {4'h0, camera_reg};
      mirror_high = {5'h00, second_reg[2], first_reg[2], first_reg[4]};
      mirror_low = {1'b0, second_reg[3], second_reg[0], second_reg[1], |camera_reg,
                    first_reg[1], first_reg[0], first_reg[3]};
      enable_high = enable_high_reg;
      enable_low = enable_low_reg;
      port_irq = |{mirror_high & enable_high_reg, mirror_low & enable_low_reg};
   end

endmodule // port_irq_unit

// ### hw/irq_hub.sv
// interrupt aggregation of the two receive ports and the camera transmit port
`timescale 1ns/1ps
`include "irq_regs.svh"

// How it works
// - interrupt leaves on a dedicated pin, governed by master control and status.
// - sources are receive port 0, receive port 1 and camera transmit port.
// - a pending condition holds until its status register is read.
// - status bits latch whatever their enables; enables gate the pin and master status bits 7, 1 and 0.
// - pin asserts only with source enable and master enable both set.
// - any general-purpose pin can carry the interrupt through its control register.
// - general-purpose pin 3 alone is open-drain, preferred for the interrupt.
// - master control bit 7 master enable, bit 0 port 0, bit 1 port 1.
// - each port has high and low enable registers selecting port conditions.
// - each port has read-only high and low mirrors of its status bits.
// - port conditions clear on first, second or camera status reads; mirrors don't.
// - an enabled interrupt with master enable set drives the pin low.
// - master status shows which receive port has an interrupt pending.
// - master status bit 7 global, bit 4 camera transmit, bits 1 and 0 ports.
module irq_hub (
   input wire logic mclk,
   input wire logic reset_n,
   input irq_pkg::reg_req_s req,
   output logic [7:0] rdata,
   input irq_pkg::port_event_s port0_events,
   input irq_pkg::port_event_s port1_events,
   input wire logic [1:0] pass_level,
   input wire logic [1:0] lock_level,
   input wire logic camera_tx_event,
   input wire logic [3:0] gpio_in,
   output logic [3:0] gpio_out,
   output logic [3:0] gpio_oe,
   output logic irq_pin_n
);
   logic [7:0] control_reg, control_next;
   logic [7:0] select_reg, select_next;
   logic camera_tx_reg, camera_tx_next;
   logic [7:0] rdata_reg, rdata_next;
   logic irq_pin_n_reg, irq_pin_n_next;
   logic [3:0] gpio_out_reg, gpio_out_next;
   logic [3:0] gpio_oe_reg, gpio_oe_next;
   logic [7:0] gpio_ctl_reg [0:3];
   logic [7:0] gpio_ctl_next [0:3];
   logic [7:0] master_status;
   logic [1:0] port_irq;
   logic [1:0] wr_hi, wr_lo;
   logic global_irq;
   irq_pkg::port_clear_s clear [0:1];
   logic [7:0] sts1 [0:1];
   logic [7:0] sts2 [0:1];
   logic [7:0] csi [0:1];
   logic [7:0] mir_hi [0:1];
   logic [7:0] mir_lo [0:1];
   logic [7:0] en_hi [0:1];
   logic [7:0] en_lo [0:1];
   logic rd_port;
   logic [3:0] gpio_level;

   // -----------------------------------------------------------------
   // receive ports; writes reach every port flagged in the select
   // register, reads come from the port named in its upper field
   // -----------------------------------------------------------------
   always_comb begin
      rd_port = select_reg[4];
      for (int p = 0; p < 2; p++) begin
         wr_hi[p] = req.wr && select_reg[p] && req.addr == `OFS_PORT_ENABLE_HIGH;
         wr_lo[p] = req.wr && select_reg[p] && req.addr == `OFS_PORT_ENABLE_LOW;
         clear[p].status_first = req.rd && rd_port == p[0] &&
                                 req.addr == `OFS_PORT_STATUS_FIRST;
         clear[p].status_second = req.rd && rd_port == p[0] &&
                                  req.addr == `OFS_PORT_STATUS_SECOND;
         clear[p].camera_rx = req.rd && rd_port == p[0] &&
                              req.addr == `OFS_CAMERA_RX_STATUS;
      end
   end

   port_irq_unit port0 (
      .mclk(mclk), .reset_n(reset_n), .events(port0_events),
      .pass_level(pass_level[0]), .lock_level(lock_level[0]),
      .wr_enable_high(wr_hi[0]), .wr_enable_low(wr_lo[0]), .wdata(req.wdata),
      .clear(clear[0]), .status_first(sts1[0]), .status_second(sts2[0]),
      .camera_rx_status(csi[0]), .mirror_high(mir_hi[0]), .mirror_low(mir_lo[0]),
      .enable_high(en_hi[0]), .enable_low(en_lo[0]), .port_irq(port_irq[0])
   );
   port_irq_unit port1 (
      .mclk(mclk), .reset_n(reset_n), .events(port1_events),
      .pass_level(pass_level[1]), .lock_level(lock_level[1]),
      .wr_enable_high(wr_hi[1]), .wr_enable_low(wr_lo[1]), .wdata(req.wdata),
      .clear(clear[1]), .status_first(sts1[1]), .status_second(sts2[1]),
      .camera_rx_status(csi[1]), .mirror_high(mir_hi[1]), .mirror_low(mir_lo[1]),
      .enable_high(en_hi[1]), .enable_low(en_lo[1]), .port_irq(port_irq[1])
   );

   // -----------------------------------------------------------------
   // master status and pin logic
   // -----------------------------------------------------------------
   always_comb begin
      // source bits show regardless of the master enable
      master_status = 8'h00;
      master_status[`BIT_STATUS_PORT0] = port_irq[0];
      master_status[`BIT_STATUS_PORT1] = port_irq[1];
      master_status[`BIT_STATUS_CAMERA_TX] = camera_tx_reg;
      global_irq = (port_irq[0] & control_reg[`BIT_PORT0_ENABLE]) |
                   (port_irq[1] & control_reg[`BIT_PORT1_ENABLE]) |
                   (camera_tx_reg & control_reg[`BIT_CAMERA_TX_ENABLE]);
      master_status[`BIT_STATUS_GLOBAL] = global_irq;
   end

   // -----------------------------------------------------------------
   // registers and read data
   // -----------------------------------------------------------------
   always_comb begin
      control_next = control_reg;
      select_next = select_reg;
      if (req.wr && req.addr == `OFS_MASTER_CONTROL)
         control_next = req.wdata;
      if (req.wr && req.addr == `OFS_PORT_SELECT)
         select_next = req.wdata;
      camera_tx_next = ((req.rd && req.addr == `OFS_CAMERA_TX_STATUS) ? 1'b0 :
                        camera_tx_reg) | camera_tx_event;
      for (int g = 0; g < `GPIO_COUNT; g++) begin
         gpio_ctl_next[g] = gpio_ctl_reg[g];
         if (req.wr && req.addr == `OFS_GPIO_CONTROL_BASE + 8'(g))
            gpio_ctl_next[g] = req.wdata;
      end
      rdata_next = 8'h00;
      if (req.rd) begin
         unique case (req.addr)
            `OFS_MASTER_CONTROL: rdata_next = control_reg;
            `OFS_MASTER_STATUS: rdata_next = master_status;
            `OFS_CAMERA_TX_STATUS: rdata_next = {7'h00, camera_tx_reg};
            `OFS_PORT_SELECT: rdata_next = select_reg;
            `OFS_PORT_STATUS_FIRST: rdata_next = sts1[rd_port];
            `OFS_PORT_STATUS_SECOND: rdata_next = sts2[rd_port];
            `OFS_CAMERA_RX_STATUS: rdata_next = csi[rd_port];
            `OFS_PORT_ENABLE_HIGH: rdata_next = en_hi[rd_port];
            `OFS_PORT_ENABLE_LOW: rdata_next = en_lo[rd_port];
            `OFS_PORT_MIRROR_HIGH: rdata_next = mir_hi[rd_port];
            `OFS_PORT_MIRROR_LOW: rdata_next = mir_lo[rd_port];
            `OFS_GPIO_CONTROL_BASE: rdata_next = gpio_ctl_reg[0];
            `OFS_GPIO_CONTROL_BASE + 8'h01: rdata_next = gpio_ctl_reg[1];
            `OFS_GPIO_CONTROL_BASE + 8'h02: rdata_next = gpio_ctl_reg[2];
            `OFS_GPIO_CONTROL_BASE + 8'h03: rdata_next = {gpio_ctl_reg[3][7:4],
                                                         gpio_in[3], gpio_ctl_reg[3][2:0]};
            default: rdata_next = 8'h00;
         endcase
      end
   end

   // -----------------------------------------------------------------
   // pin drivers; active-low interrupt, low only when master-enabled
   // -----------------------------------------------------------------
   always_comb begin
      irq_pin_n_next = ~(global_irq & control_reg[`BIT_MASTER_ENABLE]);
      for (int g = 0; g < `GPIO_COUNT; g++) begin
         gpio_level[g] = gpio_ctl_reg[g][`BIT_GPIO_IRQ_SELECT] ? irq_pin_n_next :
                         gpio_ctl_reg[g][`BIT_GPIO_OUT_VALUE];
         if (g == `OPENDRAIN_GPIO_INDEX) begin
            // open drain: only ever pulls low, the pull-up gives the high
            gpio_out_next[g] = 1'b0;
            gpio_oe_next[g] = gpio_ctl_reg[g][`BIT_GPIO_OUT_ENABLE] & ~gpio_level[g];
         end else begin
            gpio_out_next[g] = gpio_level[g];
            gpio_oe_next[g] = gpio_ctl_reg[g][`BIT_GPIO_OUT_ENABLE];
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         control_reg <= `RESET_MASTER_CONTROL;
         select_reg <= `RESET_PORT_SELECT;
         camera_tx_reg <= 1'b0;
         rdata_reg <= 8'h00;
         irq_pin_n_reg <= 1'b1;
         gpio_out_reg <= 4'h0;
         gpio_oe_reg <= 4'h0;
         for (int g = 0; g < `GPIO_COUNT; g++)
            gpio_ctl_reg[g] <= `RESET_GPIO_CONTROL;
      end else begin
         control_reg <= control_next;
         select_reg <= select_next;
         camera_tx_reg <= camera_tx_next;
         rdata_reg <= rdata_next;
         irq_pin_n_reg <= irq_pin_n_next;
         gpio_out_reg <= gpio_out_next;
         gpio_oe_reg <= gpio_oe_next;
         for (int g = 0; g < `GPIO_COUNT; g++)
            gpio_ctl_reg[g] <= gpio_ctl_next[g];
      end
   end

   assign rdata = rdata_reg;
   assign irq_pin_n = irq_pin_n_reg;
   assign gpio_out = gpio_out_reg;
   assign gpio_oe = gpio_oe_reg;

endmodule // irq_hub

// ### tb/host_model.sv
// host side model: drives register accesses into the interrupt hub
`timescale 1ns/1ps
module host_model (
   input wire logic mclk,
   input wire logic [7:0] rdata,
   output irq_pkg::reg_req_s req
);
   initial req = '0;
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk) req <= '{1'b1, 1'b0, a, d};
      @(posedge mclk) req <= '0;
   endtask
   // read data is registered, so it is taken just after the accepting edge
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge mclk) req <= '{1'b0, 1'b1, a, 8'h00};
      @(posedge mclk) req <= '0;
      #1 d = rdata;
   endtask
endmodule // host_model

// ### tb/irq_hub_sva.sv
// port assertions of the interrupt hub
`timescale 1ns/1ps
module irq_hub_sva (
   input wire logic mclk,
   input wire logic reset_n,
   input irq_pkg::reg_req_s req,
   input wire logic [7:0] rdata,
   input irq_pkg::port_event_s port0_events,
   input irq_pkg::port_event_s port1_events,
   input wire logic [1:0] pass_level,
   input wire logic [1:0] lock_level,
   input wire logic camera_tx_event,
   input wire logic [3:0] gpio_in,
   input wire logic [3:0] gpio_out,
   input wire logic [3:0] gpio_oe,
   input wire logic irq_pin_n
);
   // ---------------------------
   // shadow of written controls
   // ---------------------------
   logic [7:0] ctl_reg, ctl_next, g0_reg, g0_next, g3_reg, g3_next;
   always_comb begin
      ctl_next = ctl_reg;
      g0_next = g0_reg;
      g3_next = g3_reg;
      if (req.wr && req.addr == 8'h23) ctl_next = req.wdata;
      if (req.wr && req.addr == 8'h10) g0_next = req.wdata;
      if (req.wr && req.addr == 8'h13) g3_next = req.wdata;
   end
   always_ff @(posedge mclk) begin
      ctl_reg <= reset_n ? ctl_next : 8'h00;
      g0_reg <= reset_n ? g0_next : 8'h00;
      g3_reg <= reset_n ? g3_next : 8'h00;
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (!reset_n);
   a_master_gate: assert property ((!ctl_reg[7]) [*2] |-> irq_pin_n)
      else $error("pin active with master enable clear");
   a_source_gate: assert property (((ctl_reg & 8'h13) == 8'h00) [*2] |-> irq_pin_n)
      else $error("pin active with no source enabled");
   a_camera_raise: assert property (camera_tx_event && ctl_reg[7] && ctl_reg[4] && !req.wr
      ##1 !req.wr |=> !irq_pin_n)
      else $error("enabled camera event did not pull the pin low");
   a_reserved_zero: assert property (req.rd && req.addr == 8'h24 |=> (rdata & 8'h6C) == 8'h00)
      else $error("unused master status bits set");
   // masked: only the defined enable bits need read back
   a_ctl_readback: assert property (req.rd && req.addr == 8'h23 |=>
      (rdata & 8'h93) == (ctl_reg & 8'h93))
      else $error("master control readback differs");
   a_opendrain_gpio_pin_low: assert property (gpio_out[3] == 1'b0)
      else $error("open-drain pin driven high");
   a_opendrain_gpio_pin_sink: assert property ((g3_reg[2] && g3_reg[0]) [*2] ##0 $stable(irq_pin_n)
      |-> gpio_oe[3] == !irq_pin_n)
      else $error("open-drain pin does not follow interrupt");
   a_gpio_route: assert property ((g0_reg[2] && g0_reg[0]) [*2] ##0 $stable(irq_pin_n)
      |-> gpio_out[0] == irq_pin_n && gpio_oe[0])
      else $error("routed pin does not follow interrupt");
endmodule // irq_hub_sva

bind irq_hub irq_hub_sva irq_hub_sva_inst (.mclk(mclk), .reset_n(reset_n), .req(req),
   .rdata(rdata), .port0_events(port0_events), .port1_events(port1_events),
   .pass_level(pass_level), .lock_level(lock_level), .camera_tx_event(camera_tx_event),
   .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe(gpio_oe), .irq_pin_n(irq_pin_n));

// ### tb/irq_hub_tb.sv
// self-checking bench of the interrupt hub
`timescale 1ns/1ps
module irq_hub_tb;
   logic mclk, reset_n, cam_ev;
   irq_pkg::reg_req_s req;
   irq_pkg::port_event_s ev0, ev1, e;
   logic [7:0] rdata, d, acc, r;
   logic [1:0] pass_level, lock_level;
   logic [3:0] gpio_in, gpio_out, gpio_oe;
   logic irq_pin_n;
   int n_mismatch = 0, total_checks = 0, cyc = 0;
   irq_hub irq_hub_inst (.mclk(mclk), .reset_n(reset_n), .req(req), .rdata(rdata),
      .port0_events(ev0), .port1_events(ev1), .pass_level(pass_level),
      .lock_level(lock_level), .camera_tx_event(cam_ev), .gpio_in(gpio_in),
      .gpio_out(gpio_out), .gpio_oe(gpio_oe), .irq_pin_n(irq_pin_n));
   host_model host_model_inst (.mclk(mclk), .rdata(rdata), .req(req));
   // ------------------
   // helpers
   // ------------------
   function automatic logic [7:0] exp_first(input logic chg);
      return {3'b000, chg, 2'b00, pass_level[0], lock_level[0]};
   endfunction
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
      host_model_inst.rd(a, d);
      chk(d, exp);
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task automatic pulse(input irq_pkg::port_event_s a, b, input logic c);
      @(posedge mclk);
      ev0 <= a;
      ev1 <= b;
      cam_ev <= c;
      @(posedge mclk);
      ev0 <= '0;
      ev1 <= '0;
      cam_ev <= 1'b0;
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         n_mismatch++;
         close_out;
      end
   end
   // ------------------
   // scenarios
   // ------------------
   initial begin
      reset_n = 1'b0;
      ev0 = '0;
      ev1 = '0;
      cam_ev = 1'b0;
      gpio_in = 4'h0;
      void'($urandom(59));
      pass_level = 2'($urandom);
      lock_level = 2'($urandom);
      repeat (2) @(posedge mclk);
      reset_n <= 1'b1;
      rchk(8'h23, 8'h00);
      rchk(8'hF0, 8'h00);
      e = '0;
      e.lock_chg = 1'b1;
      pulse(e, '0, 1'b0);
      rchk(8'hDB, 8'h01);
      rchk(8'h24, 8'h00);
      host_model_inst.wr(8'h4C, 8'h01);
      host_model_inst.wr(8'hD9, 8'h01);
      host_model_inst.wr(8'h23, 8'h01);
      rchk(8'h24, 8'h81);
      chk({7'h00, irq_pin_n}, 8'h01);
      host_model_inst.wr(8'h23, 8'h81);
      tick(2);
      chk({7'h00, irq_pin_n}, 8'h00);
      rchk(8'hD9, 8'h01);
      rchk(8'hDB, 8'h01);
      rchk(8'hDB, 8'h01);
      fork
         rchk(8'h4D, exp_first(1'b1));
         pulse(e, '0, 1'b0);
      join
      rchk(8'h4D, exp_first(1'b1));
      rchk(8'h4D, exp_first(1'b0));
      tick(2);
      chk({7'h00, irq_pin_n}, 8'h01);
      host_model_inst.wr(8'h4C, 8'h12);
      host_model_inst.wr(8'hD9, 8'h10);
      host_model_inst.wr(8'h23, 8'h82);
      e = '0;
      e.buffer_err = 1'b1;
      pulse('0, e, 1'b0);
      rchk(8'h24, 8'h82);
      chk({7'h00, irq_pin_n}, 8'h00);
      rchk(8'hDB, 8'h10);
      rchk(8'h4E, 8'h10);
      rchk(8'h4E, 8'h00);
      host_model_inst.wr(8'h23, 8'h90);
      pulse('0, '0, 1'b1);
      rchk(8'h24, 8'h90);
      chk({7'h00, irq_pin_n}, 8'h00);
      rchk(8'h37, 8'h01);
      rchk(8'h24, 8'h00);
      host_model_inst.wr(8'h4C, 8'h01);
      host_model_inst.wr(8'h23, 8'h00);
      acc = 8'h00;
      repeat (8) begin
         r = 8'($urandom);
         host_model_inst.wr(8'hD8, r & 8'h07);
         rchk(8'hD8, r & 8'h07);
         e = '0;
         e.camera_rx_err = r[7:4];
         acc = acc | {4'h0, r[7:4]};
         pulse(e, '0, 1'b0);
      end
      rchk(8'hDB, (acc != 8'h00) ? 8'h08 : 8'h00);
      rchk(8'h7A, acc);
      rchk(8'h7A, 8'h00);
      host_model_inst.wr(8'h23, 8'h81);
      e = '0;
      e.lock_chg = 1'b1;
      pulse(e, '0, 1'b0);
      host_model_inst.wr(8'h10, 8'h05);
      host_model_inst.wr(8'h13, 8'h05);
      tick(2);
      chk({6'h00, gpio_out[0], gpio_oe[0]}, 8'h01);
      chk({6'h00, gpio_out[3], gpio_oe[3]}, 8'h01);
      rchk(8'h4D, exp_first(1'b1));
      tick(2);
      chk({6'h00, gpio_out[0], gpio_oe[0]}, 8'h03);
      chk({6'h00, gpio_out[3], gpio_oe[3]}, 8'h00);
      @(posedge mclk) gpio_in <= 4'h8;
      rchk(8'h13, 8'h0D);
      close_out;
   end
endmodule // irq_hub_tb
